/* File: fs_pkg.sv */
/*
  Shared constants for the file access frame engine: frame offsets, option
  bits, command codes, status codes, timing counts and register map.
  Assumes a 40 MHz module clock.
*/
package fs_pkg;
  // ==========================================================
  // frame layout (byte offsets within the frame)
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] OFS_TYPE = 12'h003;
  localparam logic [IDX_W-1:0] OFS_ID = 12'h004;
  localparam logic [IDX_W-1:0] OFS_CMD = 12'h005;
  localparam logic [IDX_W-1:0] OFS_ARG = 12'h006;
  localparam logic [IDX_W-1:0] OFS_OPT = 12'h008;
  localparam logic [IDX_W-1:0] OFS_LEN = 12'h00c;
  localparam logic [IDX_W-1:0] OFS_RTOK = 12'h007;
  localparam logic [IDX_W-1:0] OFS_RW32 = 12'h009;
  localparam logic [IDX_W-1:0] OFS_RDATA = 12'h00d;
  localparam logic [IDX_W-1:0] OFS_HEND = 12'h026;
  // ==========================================================
  // frame types, commands, status
  localparam logic [7:0] REQ_TYPE = 8'h3b;
  localparam logic [7:0] RSP_TYPE = 8'hbb;
  localparam logic [7:0] CMD_OPEN = 8'h01;
  localparam logic [7:0] CMD_CLOSE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h04;
  localparam logic [7:0] CMD_HASH = 8'h08;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_ERR = 8'h01;
  localparam logic [7:0] CKS_BASE = 8'hff;
  localparam logic [31:0] POS_CURRENT = 32'hffffffff;
  localparam logic [15:0] LEN_ANY = 16'hffff;
  // ==========================================================
  // option bit positions
  localparam int OPT_CREATE = 0;
  localparam int OPT_EXCL = 1;
  localparam int OPT_RD = 2;
  localparam int OPT_WR = 3;
  localparam int OPT_TRUNC = 4;
  localparam int OPT_APPEND = 5;
  localparam int OPT_UNUSED = 6;
  localparam int OPT_SECURE = 7;
  // ==========================================================
  // timing
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int EXPIRE_MS = 120000;
  // ==========================================================
  // register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_FLEN = 8'h08;
  localparam logic [7:0] A_FRAMES = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h05dc0001;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {S_RX, S_EXEC, S_HASH, S_ADDR, S_WAIT, S_LOAD, S_HOLD} st_t;
endpackage

/* File: file_access_frame_engine.sv */
/*
  File access frame engine: takes request frames (from the frame type byte
  to the check byte) as a byte stream, runs open, close, read, write and
  hash against one file held in an external byte memory, and streams back
  the response frame. Registers over APB.
  Assumes: synchronous byte RAM with one cycle read latency, an external
  digest engine, all multi-byte fields big endian.
*/
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module file_access_frame_engine
  import fs_pkg::*;
#(
  parameter int TOKENS = 4,
  parameter int MEM_AW = 12,
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int EXPIRE_TICKS = EXPIRE_MS
)(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // request byte stream
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  input wire logic RX_LAST_I,
  output logic RX_READY_O,
  // response byte stream
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  output logic TX_LAST_O,
  input wire logic TX_READY_I,
  // file memory
  output logic [MEM_AW-1:0] MEM_ADDR_O,
  output logic MEM_WE_O,
  output logic [7:0] MEM_WDATA_O,
  input wire logic [7:0] MEM_RDATA_I,
  // digest engine
  output logic HASH_REQ_O,
  input wire logic HASH_DONE_I,
  input wire logic [255:0] HASH_DIGEST_I
);
  localparam int TW = (TOKENS > 1) ? $clog2(TOKENS) : 1;
  localparam int CW = $clog2(EXPIRE_TICKS + 2);
  localparam int DW = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // state
  st_t st_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [7:0] sum_reg;
  logic [7:0] type_reg, id_reg, cmd_reg, opt_reg, prev_reg;
  logic [15:0] arg_reg, len_reg;
  logic [31:0] pos_reg;
  logic werr_reg;
  logic fexist_reg, fsecure_reg;
  logic [31:0] flen_reg, frames_reg, ctrl_reg;
  logic [TOKENS-1:0] tv_reg, trd_reg, twr_reg, tapp_reg;
  logic [31:0] tpos_reg [TOKENS];
  logic [7:0] rstat_reg;
  logic [15:0] rtok_reg;
  logic [31:0] rw32_reg;
  logic [IDX_W-1:0] rlast_reg;
  logic [255:0] dig_reg;
  logic [DW-1:0] div_reg;
  logic tick_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, rxrdy_reg;
  logic [7:0] txd_reg;
  logic txv_reg, txl_reg, hreq_reg, mwe_reg;
  logic [MEM_AW-1:0] maddr_reg;
  logic [7:0] mwd_reg;

  // ==========================================================
  // request decode
  wire take = rxrdy_reg & RX_VALID_I;
  wire [TW-1:0] tsel = TW'(arg_reg - 16'h0001);
  wire tok_ok = (arg_reg != 16'h0000) && (arg_reg <= 16'(TOKENS)) && tv_reg[tsel];
  wire [31:0] tpos = tpos_reg[tsel];
  wire frame_ok = (sum_reg == CKS_BASE) && (type_reg == REQ_TYPE)
    && (idx_reg > OFS_ARG) && ctrl_reg[0];
  wire is_open = cmd_reg == CMD_OPEN;
  wire is_read = cmd_reg == CMD_READ;
  wire is_write = cmd_reg == CMD_WRITE;
  wire is_hash = cmd_reg == CMD_HASH;
  wire is_close = cmd_reg == CMD_CLOSE;

  // open option checks
  wire o_cr = opt_reg[OPT_CREATE];
  wire o_ex = opt_reg[OPT_EXCL];
  wire o_rd = opt_reg[OPT_RD];
  wire o_wr = opt_reg[OPT_WR];
  wire o_tr = opt_reg[OPT_TRUNC];
  wire o_se = opt_reg[OPT_SECURE];
  wire new_sec = (o_tr | ~fexist_reg) ? o_se : fsecure_reg;
  wire [31:0] open_len = (o_tr | ~fexist_reg) ? 32'h0 : flen_reg;
  logic [TW-1:0] free_idx;
  logic free_found;
  wire open_ok = (o_rd | o_wr)
    && !opt_reg[OPT_UNUSED]
    && (!o_se || (o_wr && ((o_cr && o_ex) || o_tr)))
    && (fexist_reg ? !o_ex : o_cr)
    && !(new_sec && o_rd)
    && free_found;

  // read sizing
  wire [31:0] rd_base = (pos_reg == POS_CURRENT) ? tpos : pos_reg;
  wire [31:0] rd_avail = (flen_reg > rd_base) ? flen_reg - rd_base : 32'h0;
  wire [15:0] rd_lim = {5'h00, ctrl_reg[26:16]};
  wire [15:0] rd_want = (len_reg == LEN_ANY || len_reg > rd_lim) ? rd_lim : len_reg;
  wire [15:0] rd_n = (rd_avail < 32'(rd_want)) ? rd_avail[15:0] : rd_want;
  wire read_ok = tok_ok && trd_reg[tsel] && !fsecure_reg;

  // write placement
  wire [31:0] wr_start = tapp_reg[tsel] ? flen_reg
    : ((pos_reg == POS_CURRENT) ? tpos : pos_reg);
  wire [31:0] wr_cnt = (idx_reg > OFS_RDATA) ? 32'(idx_reg - OFS_RDATA) : 32'h0;
  wire [31:0] wr_end = wr_start + wr_cnt;
  wire write_ok = tok_ok && twr_reg[tsel] && !werr_reg;
  wire [31:0] wd_addr = wr_start + 32'(idx_reg) - 32'(OFS_RDATA);
  wire wd_byte = take && is_write && (idx_reg > OFS_LEN);
  wire wd_fit = wd_addr < (32'h1 << MEM_AW);
  wire wd_go = wd_byte && tok_ok && twr_reg[tsel] && wd_fit;

  // execution outcome
  wire exec = (st_reg == S_EXEC) && frame_ok;
  wire cmd_ok = is_open ? open_ok : is_close ? tok_ok : is_read ? read_ok
    : is_write ? write_ok : is_hash ? fexist_reg : 1'b0;
  wire touch_any = exec && (is_read || is_write) && tok_ok;

  // free token finder, lowest index first
  always_comb
  begin
    free_idx = '0;
    free_found = 1'b0;
    for (int i = TOKENS - 1; i >= 0; i--)
    begin
      if (!tv_reg[i])
      begin
        free_idx = TW'(i);
        free_found = 1'b1;
      end
    end
  end

  // ==========================================================
  // idle tick and per-token expiry
  // a 1 ms tick keeps the two-minute counters at 17 bits instead of 33
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I || div_reg == DW'(TICK_CYCLES - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
    tick_reg <= !RST_I && (div_reg == DW'(TICK_CYCLES - 1));
  end

  logic [TOKENS-1:0] expired;
  genvar g;
  generate
    for (g = 0; g < TOKENS; g++)
    begin : tmr
      logic [CW-1:0] cnt_reg;
      wire touch = touch_any && (tsel == TW'(g));
      // a reference in the expiry cycle keeps the token alive
      always_ff @(posedge MCLK_I)
      begin
        if (RST_I || !tv_reg[g] || touch)
          cnt_reg <= '0;
        else if (tick_reg && cnt_reg <= CW'(EXPIRE_TICKS))
          cnt_reg <= cnt_reg + 1'b1;
      end
      assign expired[g] = tv_reg[g] && !touch && (cnt_reg > CW'(EXPIRE_TICKS));
    end
  endgenerate

  // ==========================================================
  // token table and file state
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      tv_reg <= '0;
      trd_reg <= '0;
      twr_reg <= '0;
      tapp_reg <= '0;
      fexist_reg <= 1'b0;
      fsecure_reg <= 1'b0;
      flen_reg <= 32'h0;
      frames_reg <= 32'h0;
    end
    else
    begin
      tv_reg <= tv_reg & ~expired;
      if (exec)
        frames_reg <= frames_reg + 32'h1;
      if (exec && cmd_ok && is_open)
      begin
        tv_reg[free_idx] <= 1'b1;
        trd_reg[free_idx] <= o_rd;
        twr_reg[free_idx] <= o_wr;
        tapp_reg[free_idx] <= opt_reg[OPT_APPEND];
        tpos_reg[free_idx] <= 32'h0;
        fexist_reg <= 1'b1;
        fsecure_reg <= new_sec;
        flen_reg <= open_len;
      end
      if (exec && cmd_ok && is_close)
        tv_reg[tsel] <= 1'b0;
      if (exec && cmd_ok && is_read)
        tpos_reg[tsel] <= rd_base + 32'(rd_n);
      if (exec && cmd_ok && is_write)
      begin
        tpos_reg[tsel] <= wr_end;
        if (wr_end > flen_reg)
          flen_reg <= wr_end;
      end
    end
  end

  // ==========================================================
  // response fields, latched at execution; the digest is latched when the digest engine signals done
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      rstat_reg <= ST_OK;
      rtok_reg <= 16'h0;
      rw32_reg <= 32'h0;
      rlast_reg <= OFS_ARG;
      dig_reg <= '0;
    end
    else if (exec)
    begin
      rstat_reg <= cmd_ok ? ST_OK : ST_ERR;
      rtok_reg <= is_open ? 16'(free_idx) + 16'h1 : arg_reg;
      rw32_reg <= is_open ? open_len : is_read ? rd_base : wr_end;
      if (!cmd_ok || is_close)
        rlast_reg <= OFS_ARG;
      else if (is_hash)
        rlast_reg <= OFS_HEND;
      else if (is_read)
        rlast_reg <= OFS_LEN + IDX_W'(rd_n);
      else
        rlast_reg <= OFS_LEN;
    end
    else if (st_reg == S_HASH && HASH_DONE_I)
      dig_reg <= HASH_DIGEST_I;
  end

  // ==========================================================
  // byte sequencer: receive, execute, hash wait, transmit
  wire [4:0] hidx = 5'(idx_reg - OFS_RTOK);
  logic [7:0] tx_byte;
  always_comb
  begin
    tx_byte = MEM_RDATA_I;
    if (idx_reg == rlast_reg + 1'b1)
      tx_byte = CKS_BASE - sum_reg;
    else if (idx_reg == OFS_TYPE)
      tx_byte = RSP_TYPE;
    else if (idx_reg == OFS_ID)
      tx_byte = id_reg;
    else if (idx_reg == OFS_CMD)
      tx_byte = cmd_reg;
    else if (idx_reg == OFS_ARG)
      tx_byte = rstat_reg;
    else if (is_hash)
      tx_byte = dig_reg[8 * (31 - int'(hidx)) +: 8];
    else if (idx_reg == OFS_RTOK)
      tx_byte = rtok_reg[15:8];
    else if (idx_reg == OFS_OPT)
      tx_byte = rtok_reg[7:0];
    else if (idx_reg < OFS_RDATA)
      tx_byte = rw32_reg[8 * (3 - int'(idx_reg - OFS_RW32)) +: 8];
  end

  wire last_tx = idx_reg == rlast_reg + 1'b1;
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      st_reg <= S_RX;
      idx_reg <= OFS_TYPE;
      sum_reg <= 8'h00;
      rxrdy_reg <= 1'b1;
      txv_reg <= 1'b0;
      txl_reg <= 1'b0;
      txd_reg <= 8'h00;
      hreq_reg <= 1'b0;
      werr_reg <= 1'b0;
    end
    else
    begin
      unique case (st_reg)
        S_RX:
        if (take)
        begin
          sum_reg <= sum_reg + RX_DATA_I;
          idx_reg <= idx_reg + 1'b1;
          prev_reg <= RX_DATA_I;
          if (wd_byte && !wd_go)
            werr_reg <= 1'b1;
          if (RX_LAST_I)
          begin
            rxrdy_reg <= 1'b0;
            st_reg <= S_EXEC;
          end
        end
        S_EXEC:
        begin
          idx_reg <= OFS_TYPE;
          sum_reg <= 8'h00;
          werr_reg <= 1'b0;
          if (frame_ok && cmd_ok && is_hash)
          begin
            hreq_reg <= 1'b1;
            st_reg <= S_HASH;
          end
          else if (!frame_ok || id_reg == 8'h00)
          begin
            rxrdy_reg <= 1'b1;
            st_reg <= S_RX;
          end
          else
            st_reg <= S_ADDR;
        end
        S_HASH:
        if (HASH_DONE_I)
        begin
          hreq_reg <= 1'b0;
          rxrdy_reg <= id_reg == 8'h00;
          st_reg <= (id_reg == 8'h00) ? S_RX : S_ADDR;
        end
        S_ADDR:
          st_reg <= S_WAIT;
        S_WAIT:
          st_reg <= S_LOAD;
        S_LOAD:
        begin
          txd_reg <= tx_byte;
          txv_reg <= 1'b1;
          txl_reg <= last_tx;
          sum_reg <= sum_reg + tx_byte;
          st_reg <= S_HOLD;
        end
        S_HOLD:
        if (TX_READY_I)
        begin
          txv_reg <= 1'b0;
          txl_reg <= 1'b0;
          idx_reg <= last_tx ? OFS_TYPE : idx_reg + 1'b1;
          sum_reg <= last_tx ? 8'h00 : sum_reg;
          rxrdy_reg <= last_tx;
          st_reg <= last_tx ? S_RX : S_ADDR;
        end
      endcase
    end
  end

  // header capture; names past the fixed fields need no terminator
  always_ff @(posedge MCLK_I)
  begin
    if (take)
    begin
      if (idx_reg == OFS_TYPE)
        type_reg <= RX_DATA_I;
      if (idx_reg == OFS_ID)
        id_reg <= RX_DATA_I;
      if (idx_reg == OFS_CMD)
        cmd_reg <= RX_DATA_I;
      if (idx_reg == OFS_ARG || idx_reg == OFS_RTOK)
        arg_reg <= {arg_reg[7:0], RX_DATA_I};
      if (idx_reg == OFS_OPT)
        opt_reg <= RX_DATA_I;
      if (idx_reg >= OFS_OPT && idx_reg < OFS_LEN)
        pos_reg <= {pos_reg[23:0], RX_DATA_I};
      if (idx_reg == OFS_LEN || idx_reg == OFS_RDATA)
        len_reg <= {len_reg[7:0], RX_DATA_I};
    end
  end

  // ==========================================================
  // memory port: write data trails one byte so the check byte is never stored
  // bytes already written stay written if the check byte later fails
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      mwe_reg <= 1'b0;
      maddr_reg <= '0;
      mwd_reg <= 8'h00;
    end
    else if (st_reg == S_ADDR)
    begin
      mwe_reg <= 1'b0;
      maddr_reg <= MEM_AW'(rw32_reg + 32'(idx_reg) - 32'(OFS_RDATA));
    end
    else
    begin
      mwe_reg <= wd_go;
      maddr_reg <= wd_go ? MEM_AW'(wd_addr) : maddr_reg;
      mwd_reg <= prev_reg;
    end
  end

  // ==========================================================
  // apb slave: zero wait states, error on unmapped offsets
  wire setup = PSEL_I && !PENABLE_I;
  wire mapped = PADDR_I == A_CTRL || PADDR_I == A_STAT
    || PADDR_I == A_FLEN || PADDR_I == A_FRAMES;
  wire [31:0] rd_mux = (PADDR_I == A_CTRL) ? ctrl_reg
    : (PADDR_I == A_STAT) ? {29'h0, st_reg != S_RX, fsecure_reg, fexist_reg}
    : (PADDR_I == A_FLEN) ? flen_reg
    : (PADDR_I == A_FRAMES) ? frames_reg : 32'h0;
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      ctrl_reg <= CTRL_RST;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= setup ? rd_mux : prdata_reg;
      if (PSEL_I && PENABLE_I && pready_reg && PWRITE_I && PADDR_I == A_CTRL)
        ctrl_reg <= PWDATA_I;
    end
  end

  // outputs straight from flops
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign RX_READY_O = rxrdy_reg;
  assign TX_DATA_O = txd_reg;
  assign TX_VALID_O = txv_reg;
  assign TX_LAST_O = txl_reg;
  assign MEM_ADDR_O = maddr_reg;
  assign MEM_WE_O = mwe_reg;
  assign MEM_WDATA_O = mwd_reg;
  assign HASH_REQ_O = hreq_reg;
endmodule

/* File: fafe_asserts.sv */
/*
  Port checker for the file access frame engine.
  Assumes it is bound to the engine top and that one clock drives all.
*/
`timescale 1ns/1ps
module fafe_checker (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // byte streams
  input wire logic RX_VALID_I,
  input wire logic RX_LAST_I,
  input wire logic RX_READY_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_VALID_O,
  input wire logic TX_LAST_O,
  input wire logic TX_READY_I,
  // digest engine
  input wire logic HASH_REQ_O,
  input wire logic HASH_DONE_I
);
  // ==========================================================
  // steps of a transfer
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  sequence apb_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence rx_end;
    RX_VALID_I && RX_READY_O && RX_LAST_I;
  endsequence
  sequence tx_take;
    TX_VALID_O && TX_READY_I;
  endsequence
  sequence tx_gap;
    !TX_VALID_O [*3] ##1 TX_VALID_O;
  endsequence
  // ==========================================================
  // properties
  a_pready_setup: assert property (apb_setup |=> PREADY_O)
    else $error("ready missing after setup");
  a_pready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_slverr_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O)
    && $stable(TX_LAST_O)) else $error("response byte dropped early");
  a_tx_next_gap: assert property (tx_take ##0 !TX_LAST_O |=> tx_gap)
    else $error("next response byte mistimed");
  a_rx_stop: assert property (rx_end |=> !RX_READY_O ##1 (RX_READY_O or !RX_READY_O [*2]))
    else $error("request accepted after check byte");
  a_rx_busy: assert property (TX_VALID_O |-> !RX_READY_O)
    else $error("request taken during response");
  a_hash_quiet: assert property (HASH_REQ_O |-> !TX_VALID_O)
    else $error("response before digest");
  a_hash_hold: assert property (HASH_REQ_O && !HASH_DONE_I |=> HASH_REQ_O)
    else $error("digest request withdrawn");
  a_hash_drop: assert property (HASH_REQ_O && HASH_DONE_I |=> !HASH_REQ_O)
    else $error("digest request kept after done");
endmodule
bind file_access_frame_engine fafe_checker u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .RX_VALID_I(RX_VALID_I), .RX_LAST_I(RX_LAST_I), .RX_READY_O(RX_READY_O),
  .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_LAST_O(TX_LAST_O),
  .TX_READY_I(TX_READY_I), .HASH_REQ_O(HASH_REQ_O), .HASH_DONE_I(HASH_DONE_I));

/* File: fafe_far_side.sv */
/*
  Far side of the engine: response sink that stalls at random, file byte
  memory and a slow digest engine.
  Assumes the bench seeds the random generator once.
*/
`timescale 1ns/1ps
module fafe_far_side #(
  parameter logic [255:0] DIG = {8{32'h1f2e3d4c}}
)(
  // clock
  input wire logic clk_i,
  // response sink
  output logic tx_ready_o,
  // file memory
  input wire logic [11:0] mem_addr_i,
  input wire logic mem_we_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o,
  // digest engine
  input wire logic hash_req_i,
  output logic hash_done_o,
  output logic [255:0] hash_digest_o
);
  logic [7:0] mem [4096];
  logic [4:0] cnt_reg = 5'h00;
  logic done_reg = 1'b0;
  // ==========================================================
  // sink stalls one cycle in four to test holding
  initial tx_ready_o = 1'b1;
  always @(posedge clk_i)
    tx_ready_o <= ($urandom % 4) != 0;
  // one cycle read latency like a sync ram
  always @(posedge clk_i)
  begin
    if (mem_we_i)
      mem[mem_addr_i] <= mem_wdata_i;
    mem_rdata_o <= mem[mem_addr_i];
  end
  // digest takes 20 cycles; digest lines garbage outside done
  always @(posedge clk_i)
  begin
    done_reg <= 1'b0;
    if (hash_req_i && !done_reg)
      cnt_reg <= (cnt_reg == 5'h13) ? 5'h00 : cnt_reg + 5'h01;
    if (hash_req_i && !done_reg && cnt_reg == 5'h13)
      done_reg <= 1'b1;
  end
  assign hash_done_o = done_reg;
  assign hash_digest_o = done_reg ? DIG : ~DIG;
endmodule

/* File: file_access_frame_engine_tb.sv */
/*
  Testbench for the file access frame engine: frames in, expected reply
  bytes queued, a monitor compares every accepted reply byte.
  Assumes the shortened token timer parameters set below.
*/
`timescale 1ns/1ps
module file_access_frame_engine_tb
  import fs_pkg::*;
;
  typedef logic [7:0] bq_t [$];
  localparam logic [255:0] DIG = {8{32'h1f2e3d4c}};
  localparam logic [7:0] n0 = 8'h00;
  localparam logic [7:0] n1 = 8'h01;
  localparam logic [7:0] ff = 8'hff;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] rxd = 8'h00;
  logic rxv = 1'b0;
  logic rxl = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rxr, txv, txl, txr, mwe, hreq, hdone;
  logic [7:0] txd, mwd, mrd;
  logic [11:0] maddr;
  logic [255:0] hdig;
  logic [8:0] expq [$];
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  // ==========================================================
  // design and far side
  file_access_frame_engine #(.TICK_CYCLES(4), .EXPIRE_TICKS(250)) dut (.MCLK_I(mclk),
    .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .RX_DATA_I(rxd), .RX_VALID_I(rxv), .RX_LAST_I(rxl), .RX_READY_O(rxr), .TX_DATA_O(txd),
    .TX_VALID_O(txv), .TX_LAST_O(txl), .TX_READY_I(txr), .MEM_ADDR_O(maddr),
    .MEM_WE_O(mwe), .MEM_WDATA_O(mwd), .MEM_RDATA_I(mrd), .HASH_REQ_O(hreq),
    .HASH_DONE_I(hdone), .HASH_DIGEST_I(hdig));
  fafe_far_side #(.DIG(DIG)) far (.clk_i(mclk), .tx_ready_o(txr), .mem_addr_i(maddr),
    .mem_we_i(mwe), .mem_wdata_i(mwd), .mem_rdata_o(mrd), .hash_req_i(hreq),
    .hash_done_o(hdone), .hash_digest_o(hdig));
  // ==========================================================
  // helpers
  always #12.5 mclk = ~mclk;
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // response bytes: {last flag, data}
  task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] cks(input bq_t q);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s += q[i];
    return CKS_BASE - s;
  endfunction
  // apb transfer, held until ready; result is {error, data}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [32:0] r);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // req starts at the frame id; reply tail starts at the status
  task automatic xact(input bq_t req, input bq_t tail);
    bq_t rsp;
    @(posedge mclk);
    rsp = {RSP_TYPE, req[0], req[1], tail};
    rsp.push_back(cks(rsp));
    if (req[0] != n0)
      foreach (rsp[i]) expq.push_back({i == rsp.size() - 1, rsp[i]});
    req.push_front(REQ_TYPE);
    req.push_back(cks(req));
    foreach (req[i])
    begin
      rxd <= req[i];
      rxv <= 1'b1;
      rxl <= (i == req.size() - 1);
      do @(posedge mclk); while (rxr !== 1'b1);
    end
    rxv <= 1'b0;
    rxl <= 1'b0;
  endtask
  // reply monitor: any byte without a note is a mismatch
  always @(posedge mclk)
    if (txv && txr)
      chk_byte({txl, txd}, expq.size() ? expq.pop_front() : 'x);
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    logic [32:0] r;
    logic [7:0] d [3];
    bq_t dig;
    bq_t bad = {8'h44, 8'h01, 8'h0b, 8'h0c};
    void'($urandom(79669));
    foreach (d[i]) d[i] = $urandom;
    for (int k = 0; k < 32; k++) dig.push_back(DIG[255 - 8 * k -: 8]);
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0, r);
    chk(r, {1'b0, CTRL_RST});
    apb(1'b1, A_CTRL, CTRL_RST, r);
    apb(1'b0, 8'h10, 32'h0, r);
    chk(r, {1'b1, 32'h0});
    xact({8'h01, CMD_OPEN, n0, n0, 8'h0d}, {ST_OK, n0, n1, n0, n0, n0, n0});
    xact({8'h02, CMD_WRITE, n0, n1, n0, n0, n0, n0, d[0], d[1], d[2]},
      {ST_OK, n0, n1, n0, n0, n0, 8'h03});
    xact({8'h03, CMD_READ, n0, n1, n0, n0, n0, n1, n0, n1},
      {ST_OK, n0, n1, n0, n0, n0, n1, d[1]});
    xact({8'h04, CMD_READ, n0, n1, ff, ff, ff, ff, ff, ff},
      {ST_OK, n0, n1, n0, n0, n0, 8'h02, d[2]});
    xact({8'h05, CMD_WRITE, n0, n1, ff, ff, ff, ff}, {ST_OK, n0, n1, n0, n0, n0, 8'h03});
    apb(1'b0, A_FLEN, 32'h0, r);
    chk(r, 33'h3);
    xact({8'h06, CMD_CLOSE, n0, n1}, {ST_OK});
    xact({8'h07, CMD_READ, n0, n1, n0, n0, n0, n0, ff, ff}, {ST_ERR});
    xact({8'h08, CMD_OPEN, n0, n0, 8'h98}, {ST_OK, n0, n1, n0, n0, n0, n0});
    foreach (bad[i]) xact({8'h09, CMD_OPEN, n0, n0, bad[i]}, {ST_ERR});
    xact({8'h0a, CMD_WRITE, n0, n1, n0, n0, n0, n0, d[0], d[1]},
      {ST_OK, n0, n1, n0, n0, n0, 8'h02});
    xact({8'h0b, CMD_OPEN, n0, n0, 8'h28}, {ST_OK, n0, 8'h02, n0, n0, n0, 8'h02});
    xact({8'h0c, CMD_WRITE, n0, 8'h02, n0, n0, n0, n0, d[2]},
      {ST_OK, n0, 8'h02, n0, n0, n0, 8'h03});
    xact({8'h0d, CMD_HASH, n0, n0, 8'h61}, {ST_OK, dig});
    xact({n0, CMD_CLOSE, n0, 8'h02}, {ST_OK});
    xact({8'h0e, CMD_CLOSE, n0, 8'h02}, {ST_ERR});
    repeat (1100) @(posedge mclk);
    xact({8'h0f, CMD_WRITE, n0, n1, ff, ff, ff, ff}, {ST_ERR});
    for (int n = 0; n < 500 && expq.size() > 0; n++) @(posedge mclk);
    chk(expq.size(), 33'h0);
    // idle now: file exists and is write-only
    apb(1'b0, A_STAT, 32'h0, r);
    chk(r, 33'h3);
    // with the enable bit cleared a frame is dropped and not counted
    apb(1'b1, A_CTRL, {CTRL_RST[31:1], 1'b0}, r);
    apb(1'b0, A_CTRL, 32'h0, r);
    chk(r, {1'b0, CTRL_RST[31:1], 1'b0});
    xact({n0, CMD_CLOSE, n0, n1}, {ST_OK});
    apb(1'b0, A_FRAMES, 32'h0, r);
    chk(r, 33'h13);
    tally_and_finish();
  end
endmodule
